// ---- inc/lvd_pkg.sv ----
// package: command codes, field positions, reset values for the voltage/temp command decoder
package lvd_pkg;
   // ****************************************
   // command byte layout
   // ****************************************
   localparam logic [1:0] LVD_RS_VOLT = 2'h0;     // register select for voltage and bias
   localparam logic [1:0] LVD_RS_TEMP = 2'h2;     // register select for temperature commands
   localparam logic [2:0] LVD_OP_VMSB = 3'h2;     // bits 7..5 of the voltage upper-part command
   localparam logic [3:0] LVD_OP_VLSB = 4'h6;     // bits 7..4 of the voltage lower-part command
   localparam logic [5:0] LVD_OP_BIAS = 6'h34;    // bits 7..2 of the bias command
   localparam logic [4:0] LVD_OP_TCTL = 5'h00;    // bits 7..3 of the temperature control command
   localparam logic [4:0] LVD_OP_THR1 = 5'h07;    // bits 7..3 of threshold one
   localparam logic [4:0] LVD_OP_THR2 = 5'h08;
   localparam logic [4:0] LVD_OP_THR3 = 5'h09;
   localparam logic [4:0] LVD_OP_THR4 = 5'h0a;
   localparam int LVD_BIT_TCE = 2;                 // compensation enable position
   localparam int LVD_BIT_TMF = 1;                 // filter enable position
   localparam int LVD_BIT_TME = 0;                 // measurement enable position
   // ****************************************
   // reset values and limits
   // ****************************************
   localparam logic [8:0] LVD_VCODE_RST = 9'h000;
   localparam logic [8:0] LVD_VCODE_MAX = 9'h10c;  // codes at or above give the top level
   localparam logic [15:0] LVD_BASE_MV = 16'h0fa0; // 4000 mV at code zero
   localparam logic [15:0] LVD_STEP_MV = 16'h001e; // 30 mV per code step
   localparam logic [1:0] LVD_BIAS_RST = 2'h0;
   localparam logic [1:0] LVD_BIAS_HALF = 2'h2;
   localparam logic [1:0] LVD_BIAS_THIRD = 2'h3;
   localparam logic [2:0] LVD_THR_RST = 3'h0;
   // bias ratio encoding presented to the analogue side
   typedef enum logic [2:0] {
      LVD_RATIO_QUARTER = 3'b001,
      LVD_RATIO_THIRD = 3'b010,
      LVD_RATIO_HALF = 3'b100
   } lvd_ratio_t;
endpackage : lvd_pkg

// ---- inc/lvd_if.sv ----
// interface: serial command byte channel between host and device
`timescale 1ns/1ps
interface lvd_if;
   logic cmd_valid;            // one-cycle strobe, command byte present
   logic cmd_read;             // read/write flag, 0 = write
   logic [1:0] register_select;
   logic [7:0] cmd_byte;
   modport host (output cmd_valid, output cmd_read, output register_select, output cmd_byte);
   modport device (input cmd_valid, input cmd_read, input register_select, input cmd_byte);
endinterface : lvd_if

// ---- hdl/lvd_volt_map.sv ----
// module: maps drive code and bias code to millivolt level and bias ratio
`timescale 1ns/1ps
module lvd_volt_map
   import lvd_pkg::*;
(
   input wire logic [8:0] code_i,
   input wire logic [1:0] bias_i,
   input wire logic static_mode_i,
   output logic [15:0] level_mv_o,
   output logic [2:0] ratio_o,
   output logic ratio_used_o
);
   logic [8:0] sat_code;
   // ****************************************
   // level arithmetic
   // ****************************************
   // saturate at top code
   always_comb begin
      sat_code = (code_i >= LVD_VCODE_MAX) ? LVD_VCODE_MAX : code_i;
   end
   always_comb begin
      level_mv_o = 16'(LVD_BASE_MV + 16'(sat_code) * LVD_STEP_MV);
   end
   // ****************************************
   // bias decode
   // ****************************************
   // bias code to ratio
   always_comb begin
      unique case (bias_i)
         LVD_BIAS_THIRD: ratio_o = LVD_RATIO_THIRD;
         LVD_BIAS_HALF: ratio_o = LVD_RATIO_HALF;
         default: ratio_o = LVD_RATIO_QUARTER;
      endcase
      ratio_used_o = !static_mode_i;
   end
endmodule : lvd_volt_map

// ---- hdl/lvd_host.sv ----
// module: host end, turns user setting requests into command bytes
`timescale 1ns/1ps
module lvd_host
   import lvd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,      // one-cycle request
   input wire logic [2:0] req_kind_i, // 0 vmsb,1 vlsb,2 bias,3 tctl,4..7 threshold 1..4
   input wire logic [4:0] req_value_i,
   output logic busy_o,
   lvd_if.host link
);
   logic cmd_valid_reg, cmd_valid_next;
   logic [1:0] rs_reg, rs_next;
   logic [7:0] byte_reg, byte_next;
   // ****************************************
   // command build
   // ****************************************
   // select field per command group
   always_comb begin
      cmd_valid_next = req_valid_i;
      rs_next = rs_reg;
      byte_next = byte_reg;
      if (req_valid_i) begin
         unique case (req_kind_i)
            3'h0: begin
               rs_next = LVD_RS_VOLT;
               byte_next = {LVD_OP_VMSB, req_value_i};
            end
            3'h1: begin
               rs_next = LVD_RS_VOLT;
               byte_next = {LVD_OP_VLSB, req_value_i[3:0]};
            end
            3'h2: begin
               rs_next = LVD_RS_VOLT;
               byte_next = {LVD_OP_BIAS, req_value_i[1:0]};
            end
            3'h3: begin
               rs_next = LVD_RS_TEMP;
               byte_next = {LVD_OP_TCTL, req_value_i[2:0]};
            end
            3'h4: begin
               rs_next = LVD_RS_TEMP;
               byte_next = {LVD_OP_THR1, req_value_i[2:0]};
            end
            3'h5: begin
               rs_next = LVD_RS_TEMP;
               byte_next = {LVD_OP_THR2, req_value_i[2:0]};
            end
            3'h6: begin
               rs_next = LVD_RS_TEMP;
               byte_next = {LVD_OP_THR3, req_value_i[2:0]};
            end
            3'h7: begin
               rs_next = LVD_RS_TEMP;
               byte_next = {LVD_OP_THR4, req_value_i[2:0]};
            end
         endcase
      end
   end
   // registers, all writes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cmd_valid_reg <= 1'b0;
         rs_reg <= LVD_RS_VOLT;
         byte_reg <= 8'h00;
      end else begin
         cmd_valid_reg <= cmd_valid_next;
         rs_reg <= rs_next;
         byte_reg <= byte_next;
      end
   end
   assign link.cmd_valid = cmd_valid_reg;
   assign link.cmd_read = 1'b0;
   assign link.register_select = rs_reg;
   assign link.cmd_byte = byte_reg;
   assign busy_o = cmd_valid_reg;
endmodule : lvd_host

// ---- hdl/lvd_device.sv ----
// module: device end, decodes voltage, bias and temperature commands
`timescale 1ns/1ps
// Notes on behaviour
// - opcode 010 loads voltage code bits 8..4
// - opcode 0110 loads voltage code bits 3..0
// - code zero 4 V, saturate at 10Ch
// - each code step adds 30 mV
// - bias command sets two-bit bias selector
// - static mode ignores bias selector
// - temperature control sets three enable bits
// - measurement enable gates sensor and readout
// - filter enable chooses filtered or raw result
// - compensation enable gates voltage adjustment; the device only outputs it on temp_comp_enable_o, drive level ignores it
// - four threshold commands store three-bit codes
// - host uses select 10 temp, 00 voltage
module lvd_device
   import lvd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   lvd_if.device link,
   input wire logic static_mode_i,           // static drive mode selected elsewhere
   input wire logic [7:0] raw_temp_i,        // unfiltered sensor result
   input wire logic [7:0] filt_temp_i,       // filtered sensor result
   output logic [8:0] drive_code_o,
   output logic [15:0] drive_level_mv_o,
   output logic [2:0] bias_ratio_o,
   output logic bias_used_o,
   output logic [1:0] bias_select_o,
   output logic temp_comp_enable_o,
   output logic temp_filter_enable_o,
   output logic temp_measure_enable_o,
   output logic [7:0] temperature_result_o,
   output logic readout_valid_o,
   output logic [2:0] threshold_one_code_o,
   output logic [2:0] threshold_two_code_o,
   output logic [2:0] threshold_three_code_o,
   output logic [2:0] threshold_four_code_o
);
   // ****************************************
   // held settings and derived path
   // ****************************************
   // command settings, one register per field
   logic [8:0] vcode_reg, vcode_next;
   logic [1:0] bias_reg, bias_next;
   logic tce_reg, tce_next;
   logic tmf_reg, tmf_next;
   logic tme_reg, tme_next;
   logic [2:0] thr_reg [4];
   logic [2:0] thr_next [4];
   // registered copies of the mapped outputs and of the temperature readout
   logic [15:0] level_reg, level_next;
   logic [2:0] ratio_reg, ratio_next;
   logic used_reg, used_next;
   logic [7:0] temp_reg, temp_next;
   logic rdv_reg, rdv_next;
   // mapper results, combinational
   logic [15:0] map_level;
   logic [2:0] map_ratio;
   logic map_used;
   // write strobes, one per select group
   logic wr_volt, wr_temp;

   // index of a threshold opcode, or 3'h4 if none
   // the spare index means no threshold is stored
   function automatic logic [2:0] thr_index(input logic [4:0] op);
      unique case (op)
         LVD_OP_THR1: thr_index = 3'h0;
         LVD_OP_THR2: thr_index = 3'h1;
         LVD_OP_THR3: thr_index = 3'h2;
         LVD_OP_THR4: thr_index = 3'h3;
         default: thr_index = 3'h4;
      endcase
   endfunction : thr_index

   // ****************************************
   // command decode
   // ****************************************
   // only writes are decoded; a read strobe changes nothing
   assign wr_volt = link.cmd_valid && !link.cmd_read && link.register_select == LVD_RS_VOLT;
   assign wr_temp = link.cmd_valid && !link.cmd_read && link.register_select == LVD_RS_TEMP;

   // setting next values
   always_comb begin
      logic [2:0] ti;
      ti = thr_index(link.cmd_byte[7:3]);
      vcode_next = vcode_reg;
      bias_next = bias_reg;
      tce_next = tce_reg;
      tmf_next = tmf_reg;
      tme_next = tme_reg;
      for (int i = 0; i < 4; i++) begin
         thr_next[i] = thr_reg[i];
      end
      if (wr_volt) begin
         if (link.cmd_byte[7:5] == LVD_OP_VMSB) begin
            vcode_next[8:4] = link.cmd_byte[4:0];
         end
         if (link.cmd_byte[7:4] == LVD_OP_VLSB) begin
            vcode_next[3:0] = link.cmd_byte[3:0];
         end
         if (link.cmd_byte[7:2] == LVD_OP_BIAS) begin
            bias_next = link.cmd_byte[1:0];
         end
      end
      if (wr_temp) begin
         if (link.cmd_byte[7:3] == LVD_OP_TCTL) begin
            tce_next = link.cmd_byte[LVD_BIT_TCE];
            tmf_next = link.cmd_byte[LVD_BIT_TMF];
            tme_next = link.cmd_byte[LVD_BIT_TME];
         end
         if (ti != 3'h4) begin
            thr_next[ti[1:0]] = link.cmd_byte[2:0];
         end
      end
   end

   // ****************************************
   // derived outputs
   // ****************************************
   // level and bias ratio from the held code
   lvd_volt_map u_map (
      .code_i(vcode_reg),
      .bias_i(bias_reg),
      .static_mode_i(static_mode_i),
      .level_mv_o(map_level),
      .ratio_o(map_ratio),
      .ratio_used_o(map_used)
   );

   // readout and voltage path next values
   always_comb begin
      // voltage path follows the mapper
      level_next = map_level;
      ratio_next = map_ratio;
      used_next = map_used;
      rdv_next = tme_reg;
      temp_next = 8'h00;
      if (tme_reg) begin
         temp_next = tmf_reg ? filt_temp_i : raw_temp_i;
      end
   end

   // registers, every field back to its default under reset
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         // command settings
         vcode_reg <= LVD_VCODE_RST;
         bias_reg <= LVD_BIAS_RST;
         tce_reg <= 1'b0;
         tmf_reg <= 1'b0;
         tme_reg <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            thr_reg[i] <= LVD_THR_RST;
         end
         // derived path
         level_reg <= LVD_BASE_MV;
         ratio_reg <= LVD_RATIO_QUARTER;
         used_reg <= 1'b0;
         temp_reg <= 8'h00;
         rdv_reg <= 1'b0;
      end else begin
         // command settings
         vcode_reg <= vcode_next;
         bias_reg <= bias_next;
         tce_reg <= tce_next;
         tmf_reg <= tmf_next;
         tme_reg <= tme_next;
         for (int i = 0; i < 4; i++) begin
            thr_reg[i] <= thr_next[i];
         end
         // derived path
         level_reg <= level_next;
         ratio_reg <= ratio_next;
         used_reg <= used_next;
         temp_reg <= temp_next;
         rdv_reg <= rdv_next;
      end
   end

   // ****************************************
   // outputs, straight from the registers
   // ****************************************
   // voltage code, level and bias
   assign drive_code_o = vcode_reg;
   assign drive_level_mv_o = level_reg;
   assign bias_ratio_o = ratio_reg;
   assign bias_used_o = used_reg;
   assign bias_select_o = bias_reg;
   assign temp_comp_enable_o = tce_reg;
   assign temp_filter_enable_o = tmf_reg;
   assign temp_measure_enable_o = tme_reg;
   assign temperature_result_o = temp_reg;
   assign readout_valid_o = rdv_reg;
   assign threshold_one_code_o = thr_reg[0];
   assign threshold_two_code_o = thr_reg[1];
   assign threshold_three_code_o = thr_reg[2];
   assign threshold_four_code_o = thr_reg[3];
endmodule : lvd_device

// ---- tb/lvd_link_chk.sv ----
// checker: decode and timing relations around the first command link
`timescale 1ns/1ps
module lvd_link_chk
   import lvd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic [1:0] register_select,
   input wire logic [7:0] cmd_byte,
   input wire logic [8:0] drive_code_o,
   input wire logic [15:0] drive_level_mv_o,
   input wire logic [1:0] bias_select_o,
   input wire logic [2:0] bias_ratio_o,
   input wire logic temp_comp_enable_o,
   input wire logic temp_filter_enable_o,
   input wire logic temp_measure_enable_o,
   input wire logic [7:0] temperature_result_o,
   input wire logic readout_valid_o,
   input wire logic [2:0] threshold_four_code_o
);
   // ****************************************
   // helpers and properties
   // ****************************************
   logic [15:0] lvl_exp;
   // expected level for the present code, saturated at the top code
   always_comb begin
      lvl_exp = LVD_BASE_MV + LVD_STEP_MV * ((drive_code_o >= LVD_VCODE_MAX) ?
         {7'h00, LVD_VCODE_MAX} : {7'h00, drive_code_o});
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // a write strobe with a given select field
   sequence wr_s(logic [1:0] rs);
      cmd_valid && !cmd_read && (register_select == rs);
   endsequence
   vmsb_load_a: assert property (
      wr_s(LVD_RS_VOLT) ##0 (cmd_byte[7:5] == LVD_OP_VMSB) |=>
      drive_code_o[8:4] == $past(cmd_byte[4:0])) else $error("upper code part not loaded");
   vlsb_load_a: assert property (
      wr_s(LVD_RS_VOLT) ##0 (cmd_byte[7:4] == LVD_OP_VLSB) |=>
      drive_code_o[3:0] == $past(cmd_byte[3:0])) else $error("lower code part not loaded");
   bias_load_a: assert property (
      wr_s(LVD_RS_VOLT) ##0 (cmd_byte[7:2] == LVD_OP_BIAS) |=>
      bias_select_o == $past(cmd_byte[1:0])) else $error("bias selector not loaded");
   tctl_load_a: assert property (
      wr_s(LVD_RS_TEMP) ##0 (cmd_byte[7:3] == LVD_OP_TCTL) |=>
      {temp_comp_enable_o, temp_filter_enable_o, temp_measure_enable_o} == $past(cmd_byte[2:0]))
      else $error("temperature enables not loaded");
   thr_load_a: assert property (
      wr_s(LVD_RS_TEMP) ##0 (cmd_byte[7:3] == LVD_OP_THR4) |=>
      threshold_four_code_o == $past(cmd_byte[2:0])) else $error("threshold four not loaded");
   level_map_a: assert property (
      1'b1 |=> drive_level_mv_o == $past(lvl_exp)) else $error("drive level mismatch");
   ratio_map_a: assert property (
      (bias_select_o == LVD_BIAS_THIRD) [*2] |-> bias_ratio_o == LVD_RATIO_THIRD)
      else $error("third bias ratio missing");
   idle_hold_a: assert property (
      !cmd_valid |=> $stable(drive_code_o) && $stable(bias_select_o) &&
      $stable(threshold_four_code_o)) else $error("setting changed without command");
   readout_off_a: assert property (
      !temp_measure_enable_o |=> (temperature_result_o == 8'h00) && !readout_valid_o)
      else $error("readout present while measurement off");
   host_write_a: assert property (
      cmd_valid |-> !cmd_read) else $error("host sent a read strobe");
endmodule : lvd_link_chk

// ---- tb/lvd_voltage_tempcomp_cmd_decode_tb_top.sv ----
// testbench: host and device joined on one link, a rule-breaking driver on a second
`timescale 1ns/1ps
module lvd_voltage_tempcomp_cmd_decode_tb_top
   import lvd_pkg::*;
;
   logic sys_clk_i;
   logic rst_n_i;
   logic req_valid;
   logic [2:0] req_kind;
   logic [4:0] req_value;
   logic static_mode;
   logic [7:0] raw_temp;
   logic [7:0] filt_temp;
   logic [25:0] model;
   logic [25:0] exp_s;
   logic [15:0] exp_r;
   logic [25:0] state_q[$];
   logic [15:0] level_q[$];
   logic v1;
   logic v2;
   int errors;
   int checked;
   int cycles;
   wire [25:0] snap_a;
   wire [25:0] snap_b;
   wire [15:0] lv_a;
   wire [2:0] br_a;
   wire bu_a;
   wire [7:0] tr_a;
   wire rv_a;
   wire busy;
   lvd_if link_a();
   lvd_if link_b();
   lvd_host u_lvd_host(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
      .req_kind_i(req_kind), .req_value_i(req_value), .busy_o(busy), .link(link_a.host));
   lvd_device u_lvd_device(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link_a.device),
      .static_mode_i(static_mode), .raw_temp_i(raw_temp), .filt_temp_i(filt_temp),
      .drive_code_o(snap_a[25:17]), .drive_level_mv_o(lv_a), .bias_ratio_o(br_a),
      .bias_used_o(bu_a), .bias_select_o(snap_a[16:15]), .temp_comp_enable_o(snap_a[14]),
      .temp_filter_enable_o(snap_a[13]), .temp_measure_enable_o(snap_a[12]),
      .temperature_result_o(tr_a), .readout_valid_o(rv_a), .threshold_one_code_o(snap_a[11:9]),
      .threshold_two_code_o(snap_a[8:6]), .threshold_three_code_o(snap_a[5:3]),
      .threshold_four_code_o(snap_a[2:0]));
   lvd_device u_lvd_device_b(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link_b.device),
      .static_mode_i(static_mode), .raw_temp_i(raw_temp), .filt_temp_i(filt_temp),
      .drive_code_o(snap_b[25:17]), .drive_level_mv_o(), .bias_ratio_o(), .bias_used_o(),
      .bias_select_o(snap_b[16:15]), .temp_comp_enable_o(snap_b[14]),
      .temp_filter_enable_o(snap_b[13]), .temp_measure_enable_o(snap_b[12]),
      .temperature_result_o(), .readout_valid_o(), .threshold_one_code_o(snap_b[11:9]),
      .threshold_two_code_o(snap_b[8:6]), .threshold_three_code_o(snap_b[5:3]),
      .threshold_four_code_o(snap_b[2:0]));
   lvd_link_chk u_lvd_link_chk(.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .cmd_valid(link_a.cmd_valid), .cmd_read(link_a.cmd_read),
      .register_select(link_a.register_select), .cmd_byte(link_a.cmd_byte),
      .drive_code_o(snap_a[25:17]), .drive_level_mv_o(lv_a), .bias_select_o(snap_a[16:15]),
      .bias_ratio_o(br_a), .temp_comp_enable_o(snap_a[14]), .temp_filter_enable_o(snap_a[13]),
      .temp_measure_enable_o(snap_a[12]), .temperature_result_o(tr_a), .readout_valid_o(rv_a),
      .threshold_four_code_o(snap_a[2:0]));
   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [15:0] lvl(input logic [8:0] c);
      lvl = LVD_BASE_MV + LVD_STEP_MV *
         ((c >= LVD_VCODE_MAX) ? {7'h00, LVD_VCODE_MAX} : {7'h00, c});
   endfunction : lvl
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic cmp_state(input logic [25:0] exp, input logic [25:0] act);
      checked++;
      if (act !== exp) begin
         errors++;
         $display("[ERR] %0t settings %h expected %h", $time, act, exp);
      end
   endtask : cmp_state
   task automatic cmp_val(input logic [15:0] exp, input logic [15:0] act);
      checked++;
      if (act !== exp) begin
         errors++;
         $display("[ERR] %0t value %h expected %h", $time, act, exp);
      end
   endtask : cmp_val
   // one request on the host side, expected settings noted in the queue
   task automatic send(input logic [2:0] kind, input logic [4:0] val);
      req_valid = 1'b1;
      req_kind = kind;
      req_value = val;
      case (kind)
         3'h0: model[25:21] = val;
         3'h1: model[20:17] = val[3:0];
         3'h2: model[16:15] = val[1:0];
         3'h3: model[14:12] = val[2:0];
         default: model[11 - 3 * (int'(kind) - 4) -: 3] = val[2:0];
      endcase
      state_q.push_back(model);
      @(posedge sys_clk_i);
      #1;
   endtask : send
   task automatic idle(input int n);
      req_valid = 1'b0;
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : idle
   // raw byte on the second link, strobe held across back-to-back bytes
   task automatic poke(input logic rd, input logic [1:0] rs, input logic [7:0] b);
      link_b.cmd_valid = 1'b1;
      link_b.cmd_read = rd;
      link_b.register_select = rs;
      link_b.cmd_byte = b;
      @(posedge sys_clk_i);
      #1;
   endtask : poke
   // ****************************************
   // clock, watchdog, result watcher
   // ****************************************
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      cycles = 0;
      forever begin
         @(posedge sys_clk_i);
         cycles++;
         if (cycles == 3000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            complete_run();
         end
      end
   end
   // settings one edge after the strobe, level one edge later
   initial begin
      v1 = 1'b0;
      v2 = 1'b0;
      forever begin
         @(posedge sys_clk_i);
         #1;
         if (v2) cmp_val(level_q.pop_front(), lv_a);
         if (v1) begin
            exp_s = state_q.pop_front();
            cmp_state(exp_s, snap_a);
            level_q.push_back(lvl(exp_s[25:17]));
         end
         v2 = v1;
         v1 = link_a.cmd_valid;
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n_i = 1'b0;
      req_valid = 1'b0;
      req_kind = 3'h0;
      req_value = 5'h00;
      static_mode = 1'b0;
      raw_temp = 8'h00;
      filt_temp = 8'h00;
      link_b.cmd_valid = 1'b0;
      link_b.cmd_read = 1'b0;
      link_b.register_select = 2'h0;
      link_b.cmd_byte = 8'h00;
      errors = 0;
      checked = 0;
      model = 26'h000_0000;
      void'($urandom(90716));
      repeat (20) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      cmp_state(26'h000_0000, snap_a);
      cmp_val(16'h0fa0, lv_a);
      $display("test reset done");
      for (int k = 0; k < 24; k++) send(3'(k), 5'($urandom));
      idle(3);
      $display("test command kinds done");
      // walk the code across the saturation point and back, one half at a time
      send(3'h0, 5'h10);
      send(3'h1, 5'h0b);
      send(3'h1, 5'h0c);
      send(3'h0, 5'h1f);
      send(3'h1, 5'h0f);
      send(3'h0, 5'h00);
      send(3'h1, 5'h00);
      idle(3);
      cmp_val(16'h0000, {15'h0000, busy});
      $display("test level boundaries done");
      for (int b = 0; b < 4; b++) begin
         send(3'h2, 5'(b));
         cmp_val(16'h0001, {15'h0000, busy});
         idle(2);
         exp_r = (b == 2) ? 16'h0004 : ((b == 3) ? 16'h0002 : 16'h0001);
         cmp_val(exp_r, {13'h0000, br_a});
      end
      static_mode = 1'b1;
      idle(2);
      cmp_val(16'h0000, {15'h0000, bu_a});
      static_mode = 1'b0;
      idle(2);
      cmp_val(16'h0001, {15'h0000, bu_a});
      $display("test bias done");
      raw_temp = 8'($urandom);
      filt_temp = ~raw_temp;
      send(3'h3, 5'h04);
      idle(2);
      cmp_val(16'h0000, {7'h00, rv_a, tr_a});
      cmp_val(16'h0001, {15'h0000, snap_a[14]});
      send(3'h3, 5'h01);
      idle(2);
      cmp_val({7'h01, raw_temp}, {7'h00, rv_a, tr_a});
      cmp_val(16'h0000, {15'h0000, snap_a[14]});
      send(3'h3, 5'h03);
      idle(2);
      cmp_val({7'h01, filt_temp}, {7'h00, rv_a, tr_a});
      $display("test temperature done");
      poke(1'b0, 2'h0, 8'h5f);
      poke(1'b1, 2'h0, 8'h41);
      poke(1'b0, 2'h1, 8'h62);
      poke(1'b0, 2'h3, 8'hd3);
      poke(1'b0, 2'h2, 8'h5b);
      poke(1'b0, 2'h0, 8'h3c);
      poke(1'b0, 2'h2, 8'h0f);
      poke(1'b0, 2'h2, 8'h57);
      link_b.cmd_valid = 1'b0;
      link_b.cmd_byte = ~link_b.cmd_byte;
      cmp_state(26'h3e0_0007, snap_b);
      idle(2);
      cmp_state(26'h3e0_0007, snap_b);
      $display("test refused bytes done");
      complete_run();
   end
endmodule : lvd_voltage_tempcomp_cmd_decode_tb_top
